/* File: include/amr_defs.svh */
// register offsets, field positions, masks and gain constants of the mixer routing bank
`ifndef AMR_DEFS_SVH
`define AMR_DEFS_SVH

// register offsets on the control port
`define AMR_OFS_PHONE_IN 8'h0e
`define AMR_OFS_AUX_LEFT 8'h0f
`define AMR_OFS_AUX_RIGHT 8'h10
`define AMR_OFS_CONVERTER 8'h11
`define AMR_OFS_PHONE_OUT 8'h12
`define AMR_OFS_AUX_OUT 8'h13
`define AMR_OFS_SPEAKER_OUT 8'h14
`define AMR_OFS_HEADPHONE_OUT 8'h15
`define AMR_OFS_EARPIECE_OUT 8'h16

// writable bits per register; the rest read as zero
`define AMR_MASK_PHONE_IN 8'h3f
`define AMR_MASK_INPUT 8'hff
`define AMR_MASK_PHONE_OUT 8'h1f
`define AMR_MASK_LINE_OUT 8'h0f
`define AMR_MASK_HP_EP_OUT 8'h1f
`define AMR_RESET_BYTE 8'h00

// input and converter register fields
`define AMR_LEVEL_MSB 4
`define AMR_LEVEL_LSB 0
`define AMR_BIT_PHONE_IN_SILENCE 5
`define AMR_BIT_AUX_BOOST 5
`define AMR_BIT_AUX_SILENCE 6
`define AMR_BIT_AUX_TAKE 7
`define AMR_BIT_CONV_USE_AUX 5
`define AMR_BIT_CONV_BOOST 6
`define AMR_BIT_CONV_SILENCE 7

// output routing register fields
`define AMR_BIT_OUT_SEL0 0
`define AMR_BIT_OUT_SEL1 1
`define AMR_BIT_OUT_SEL2 2
`define AMR_BIT_OUT_SEL3 3
`define AMR_BIT_OUT_SILENCE3 3
`define AMR_BIT_OUT_SILENCE4 4
`define AMR_BIT_PHONE_OUT_GATE 4

// gains in half-dB steps, two's complement
`define AMR_GAIN_FLOOR_HDB 8'ha3
`define AMR_GAIN_STEP_HDB 8'h03
`define AMR_GAIN_BOOST_HDB 8'h18
`define AMR_HP_GAIN_STEREO_HDB 8'hf4
`define AMR_HP_GAIN_MONO_HDB 8'he8
`define AMR_HP_GAIN_VOICE_HDB 8'hf4

`endif

/* File: include/amr_pkg.sv */
// types shared by the mixer routing bank modules
package amr_pkg;
	typedef struct packed {
		logic [7:0] phone_input_config;
		logic [7:0] auxiliary_left_input_config;
		logic [7:0] auxiliary_right_input_config;
		logic [7:0] converter_mixer_level;
		logic [7:0] phone_output_routing;
		logic [7:0] auxiliary_output_routing;
		logic [7:0] speaker_output_routing;
		logic [7:0] headphone_output_routing;
		logic [7:0] earpiece_output_routing;
	} amr_regs_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} amr_req_s;

	typedef struct packed {
		logic [7:0] rdata;
		logic rvalid;
	} amr_rsp_s;

	typedef struct packed {
		logic signed [7:0] gain_hdb;
		logic silence;
		logic take_aux;
	} amr_src_s;

	typedef struct packed {
		logic add_mic;
		logic add_phone_in;
		logic add_sidetone;
		logic add_left;
		logic add_right;
		logic silence;
	} amr_route_s;

	typedef struct packed {
		logic applied;
	} amr_zc_s;
endpackage

/* File: core/amr_gain_map.sv */
// level code to mixer gain, in half-dB steps
`timescale 1ns/1ps
`include "amr_defs.svh"
module amr_gain_map #(
	parameter int CODE_W = 5
) (
	// level selection
	input logic [CODE_W-1:0] level_code,
	input logic boost,
	// resulting gain
	output logic signed [7:0] gain_hdb
);
	logic [7:0] code_ext;
	logic [7:0] step_sum;

	// codes of 7 bits or more would wrap the 8-bit gain
	if (CODE_W < 1 || CODE_W > 5)
	begin : g_bad_width
		$error("amr_gain_map: CODE_W must be 1 to 5");
	end

	assign code_ext = {{(8 - CODE_W){1'b0}}, level_code};
	assign step_sum = 8'(code_ext * `AMR_GAIN_STEP_HDB);
	assign gain_hdb = 8'(`AMR_GAIN_FLOOR_HDB + step_sum + (boost ? `AMR_GAIN_BOOST_HDB : 8'h00)); // RULE3 RULE4
endmodule

/* File: core/amr_zc_mute.sv */
// silence that changes only on a zero crossing of the signal
`timescale 1ns/1ps
module amr_zc_mute (
	// clock and reset
	input logic sys_clk,
	input logic resetn,
	// control
	input logic mute_request,
	input logic zero_cross,
	// applied silence
	output logic mute_applied
);
	amr_pkg::amr_zc_s state_reg;
	amr_pkg::amr_zc_s state_next;

	// unmute waits for the crossing too, so neither edge clicks
	always_comb
	begin
		state_next = state_reg;
		if (zero_cross)
		begin
			state_next.applied = mute_request; // RULE11
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign mute_applied = state_reg.applied;
endmodule

/* File: core/amr_mixer_regs.sv */
// mixer source gain and output routing register bank
// Operation
// RULE1 - phone input code sets gain, 1.5 dB steps
// RULE2 - phone input bit 5 silences phone input
// RULE3 - left aux code sets gain, boost shifts range
// RULE4 - left aux bit 5 adds 12 dB
// RULE5 - left aux bit 6 silences left aux
// RULE6 - left aux bit 7 picks aux over converter
// RULE7 - right aux mirrors left aux fields
// RULE8 - converter code uses the aux gain table
// RULE9 - converter bit 5 borrows aux level codes
// RULE10 - converter bit 6 adds 12 dB
// RULE11 - converter bit 7 silences at zero crossing
// RULE12 - phone out adds mic, right, left; silence
// RULE13 - noise gate blocks mic to phone out
// RULE14 - aux out adds phone, right, left; silence
// RULE15 - speaker out adds phone, right, left; silence
// RULE16 - headphone adds sidetone, phone; bit 4 silences
// RULE17 - right channel right only when stereo
// RULE18 - left channel left only when stereo
// RULE19 - headphone mix gain -6 or -12 dB
// RULE20 - earpiece adds four channels; bit 4 silences
// RULE21 - external speaker amplifier gain 12 dB; this bank drives no speaker amplifier gain, only the headphone gains
// RULE22 - all fields reset to zero
`timescale 1ns/1ps
`include "amr_defs.svh"
module amr_mixer_regs (
	// clock and reset
	input logic sys_clk,
	input logic resetn,
	// register access from the serial control port
	input amr_pkg::amr_req_s reg_req,
	output amr_pkg::amr_rsp_s reg_rsp,
	// device state from outside this bank
	input logic stereo_flag,
	input logic noise_gate_on,
	input logic agc_noise_detect,
	input logic conv_zero_cross_left,
	input logic conv_zero_cross_right,
	// mixer sources
	output amr_pkg::amr_src_s phone_src,
	output amr_pkg::amr_src_s aux_left_src,
	output amr_pkg::amr_src_s aux_right_src,
	output amr_pkg::amr_src_s conv_left_src,
	output amr_pkg::amr_src_s conv_right_src,
	// output routing
	output amr_pkg::amr_route_s phone_output,
	output amr_pkg::amr_route_s aux_output,
	output amr_pkg::amr_route_s speaker_output,
	output amr_pkg::amr_route_s headphone_left_output,
	output amr_pkg::amr_route_s headphone_right_output,
	output amr_pkg::amr_route_s earpiece_output,
	// headphone amplifier gains
	output logic signed [7:0] headphone_mix_gain_hdb,
	output logic signed [7:0] headphone_voice_gain_hdb
);
	typedef struct packed {
		amr_pkg::amr_regs_s regs;
		amr_pkg::amr_rsp_s rsp;
		amr_pkg::amr_src_s phone_src;
		amr_pkg::amr_src_s aux_left_src;
		amr_pkg::amr_src_s aux_right_src;
		amr_pkg::amr_src_s conv_left_src;
		amr_pkg::amr_src_s conv_right_src;
		amr_pkg::amr_route_s phone_out;
		amr_pkg::amr_route_s aux_out;
		amr_pkg::amr_route_s spk_out;
		amr_pkg::amr_route_s hp_left_out;
		amr_pkg::amr_route_s hp_right_out;
		amr_pkg::amr_route_s ear_out;
		logic signed [7:0] hp_mix_gain;
		logic signed [7:0] hp_voice_gain;
	} amr_state_s;

	amr_state_s state_reg;
	amr_state_s state_next;

	logic signed [7:0] phone_gain;
	logic signed [7:0] aux_left_gain;
	logic signed [7:0] aux_right_gain;
	logic signed [7:0] conv_left_gain;
	logic signed [7:0] conv_right_gain;
	logic [4:0] conv_left_code;
	logic [4:0] conv_right_code;
	logic conv_left_silent;
	logic conv_right_silent;

	// writable bits of the register at this offset; zero marks an unmapped offset
	function automatic logic [7:0] amr_write_mask(input logic [7:0] addr);
		logic [7:0] mask;
		mask = 8'h00;
		case (addr)
			`AMR_OFS_PHONE_IN: mask = `AMR_MASK_PHONE_IN;
			`AMR_OFS_AUX_LEFT: mask = `AMR_MASK_INPUT;
			`AMR_OFS_AUX_RIGHT: mask = `AMR_MASK_INPUT;
			`AMR_OFS_CONVERTER: mask = `AMR_MASK_INPUT;
			`AMR_OFS_PHONE_OUT: mask = `AMR_MASK_PHONE_OUT;
			`AMR_OFS_AUX_OUT: mask = `AMR_MASK_LINE_OUT;
			`AMR_OFS_SPEAKER_OUT: mask = `AMR_MASK_LINE_OUT;
			`AMR_OFS_HEADPHONE_OUT: mask = `AMR_MASK_HP_EP_OUT;
			`AMR_OFS_EARPIECE_OUT: mask = `AMR_MASK_HP_EP_OUT;
			default: mask = 8'h00;
		endcase
		return mask;
	endfunction

	// stored byte at an offset, zero for unmapped offsets
	function automatic logic [7:0] amr_read_byte(input logic [7:0] addr, input amr_pkg::amr_regs_s regs);
		logic [7:0] data;
		data = 8'h00;
		case (addr)
			`AMR_OFS_PHONE_IN: data = regs.phone_input_config;
			`AMR_OFS_AUX_LEFT: data = regs.auxiliary_left_input_config;
			`AMR_OFS_AUX_RIGHT: data = regs.auxiliary_right_input_config;
			`AMR_OFS_CONVERTER: data = regs.converter_mixer_level;
			`AMR_OFS_PHONE_OUT: data = regs.phone_output_routing;
			`AMR_OFS_AUX_OUT: data = regs.auxiliary_output_routing;
			`AMR_OFS_SPEAKER_OUT: data = regs.speaker_output_routing;
			`AMR_OFS_HEADPHONE_OUT: data = regs.headphone_output_routing;
			`AMR_OFS_EARPIECE_OUT: data = regs.earpiece_output_routing;
			default: data = 8'h00;
		endcase
		return data & amr_write_mask(addr);
	endfunction

	// three-channel output register: a mic or phone select, right, left and a silence bit
	function automatic amr_pkg::amr_route_s amr_line_route(input logic [7:0] r, input logic first_is_mic);
		amr_pkg::amr_route_s route;
		route = '0;
		route.add_mic = first_is_mic & r[`AMR_BIT_OUT_SEL0];
		route.add_phone_in = ~first_is_mic & r[`AMR_BIT_OUT_SEL0];
		route.add_right = r[`AMR_BIT_OUT_SEL1];
		route.add_left = r[`AMR_BIT_OUT_SEL2];
		route.silence = r[`AMR_BIT_OUT_SILENCE3];
		return route;
	endfunction

	// phone input uses the boosted table: -34.5 dB at code zero
	amr_gain_map #(
		.CODE_W(5)
	) u_phone_gain (
		.level_code(state_reg.regs.phone_input_config[`AMR_LEVEL_MSB:`AMR_LEVEL_LSB]),
		.boost(1'b1),
		.gain_hdb(phone_gain)
	); // RULE1

	amr_gain_map #(
		.CODE_W(5)
	) u_aux_left_gain (
		.level_code(state_reg.regs.auxiliary_left_input_config[`AMR_LEVEL_MSB:`AMR_LEVEL_LSB]),
		.boost(state_reg.regs.auxiliary_left_input_config[`AMR_BIT_AUX_BOOST]),
		.gain_hdb(aux_left_gain)
	); // RULE3 RULE4

	amr_gain_map #(
		.CODE_W(5)
	) u_aux_right_gain (
		.level_code(state_reg.regs.auxiliary_right_input_config[`AMR_LEVEL_MSB:`AMR_LEVEL_LSB]),
		.boost(state_reg.regs.auxiliary_right_input_config[`AMR_BIT_AUX_BOOST]),
		.gain_hdb(aux_right_gain)
	); // RULE7

	// balance mode borrows each side's aux code, boost stays the converter's own
	assign conv_left_code = state_reg.regs.converter_mixer_level[`AMR_BIT_CONV_USE_AUX] ?
		state_reg.regs.auxiliary_left_input_config[`AMR_LEVEL_MSB:`AMR_LEVEL_LSB] :
		state_reg.regs.converter_mixer_level[`AMR_LEVEL_MSB:`AMR_LEVEL_LSB]; // RULE9
	assign conv_right_code = state_reg.regs.converter_mixer_level[`AMR_BIT_CONV_USE_AUX] ?
		state_reg.regs.auxiliary_right_input_config[`AMR_LEVEL_MSB:`AMR_LEVEL_LSB] :
		state_reg.regs.converter_mixer_level[`AMR_LEVEL_MSB:`AMR_LEVEL_LSB]; // RULE9

	amr_gain_map #(
		.CODE_W(5)
	) u_conv_left_gain (
		.level_code(conv_left_code),
		.boost(state_reg.regs.converter_mixer_level[`AMR_BIT_CONV_BOOST]),
		.gain_hdb(conv_left_gain)
	); // RULE8 RULE10

	amr_gain_map #(
		.CODE_W(5)
	) u_conv_right_gain (
		.level_code(conv_right_code),
		.boost(state_reg.regs.converter_mixer_level[`AMR_BIT_CONV_BOOST]),
		.gain_hdb(conv_right_gain)
	); // RULE8 RULE10

	// each converter side has its own crossing, so the two sides mute independently
	amr_zc_mute u_conv_left_mute (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.mute_request(state_reg.regs.converter_mixer_level[`AMR_BIT_CONV_SILENCE]),
		.zero_cross(conv_zero_cross_left),
		.mute_applied(conv_left_silent)
	); // RULE11

	amr_zc_mute u_conv_right_mute (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.mute_request(state_reg.regs.converter_mixer_level[`AMR_BIT_CONV_SILENCE]),
		.zero_cross(conv_zero_cross_right),
		.mute_applied(conv_right_silent)
	); // RULE11

	always_comb
	begin
		logic [7:0] wmask;
		logic [7:0] wbyte;
		logic [7:0] hp;
		logic [7:0] ep;
		logic [7:0] cpo;
		wmask = amr_write_mask(reg_req.addr);
		wbyte = reg_req.wdata & wmask;
		hp = state_reg.regs.headphone_output_routing;
		ep = state_reg.regs.earpiece_output_routing;
		cpo = state_reg.regs.phone_output_routing;
		state_next = state_reg;

		// a read in the same cycle as a write returns the old value
		state_next.rsp.rvalid = reg_req.rd;
		state_next.rsp.rdata = reg_req.rd ? amr_read_byte(reg_req.addr, state_reg.regs) : 8'h00;

		// writes to unmapped offsets are dropped
		if (reg_req.wr)
		begin
			case (reg_req.addr)
				`AMR_OFS_PHONE_IN: state_next.regs.phone_input_config = wbyte;
				`AMR_OFS_AUX_LEFT: state_next.regs.auxiliary_left_input_config = wbyte;
				`AMR_OFS_AUX_RIGHT: state_next.regs.auxiliary_right_input_config = wbyte;
				`AMR_OFS_CONVERTER: state_next.regs.converter_mixer_level = wbyte;
				`AMR_OFS_PHONE_OUT: state_next.regs.phone_output_routing = wbyte;
				`AMR_OFS_AUX_OUT: state_next.regs.auxiliary_output_routing = wbyte;
				`AMR_OFS_SPEAKER_OUT: state_next.regs.speaker_output_routing = wbyte;
				`AMR_OFS_HEADPHONE_OUT: state_next.regs.headphone_output_routing = wbyte;
				`AMR_OFS_EARPIECE_OUT: state_next.regs.earpiece_output_routing = wbyte;
				default: state_next.regs = state_reg.regs;
			endcase
		end

		// mixer sources
		state_next.phone_src.gain_hdb = phone_gain; // RULE1
		state_next.phone_src.silence = state_reg.regs.phone_input_config[`AMR_BIT_PHONE_IN_SILENCE]; // RULE2
		state_next.phone_src.take_aux = 1'b0;
		state_next.aux_left_src.gain_hdb = aux_left_gain; // RULE3
		state_next.aux_left_src.silence = state_reg.regs.auxiliary_left_input_config[`AMR_BIT_AUX_SILENCE]; // RULE5
		state_next.aux_left_src.take_aux = state_reg.regs.auxiliary_left_input_config[`AMR_BIT_AUX_TAKE]; // RULE6
		state_next.aux_right_src.gain_hdb = aux_right_gain; // RULE7
		state_next.aux_right_src.silence = state_reg.regs.auxiliary_right_input_config[`AMR_BIT_AUX_SILENCE]; // RULE7
		state_next.aux_right_src.take_aux = state_reg.regs.auxiliary_right_input_config[`AMR_BIT_AUX_TAKE]; // RULE7
		state_next.conv_left_src.gain_hdb = conv_left_gain; // RULE8
		state_next.conv_left_src.silence = conv_left_silent; // RULE11
		state_next.conv_left_src.take_aux = 1'b0;
		state_next.conv_right_src.gain_hdb = conv_right_gain; // RULE8
		state_next.conv_right_src.silence = conv_right_silent; // RULE11
		state_next.conv_right_src.take_aux = 1'b0;

		// phone output: the gate only ever removes the microphone path
		state_next.phone_out = amr_line_route(cpo, 1'b1); // RULE12
		state_next.phone_out.add_mic = cpo[`AMR_BIT_OUT_SEL0] &
			~(cpo[`AMR_BIT_PHONE_OUT_GATE] & noise_gate_on & agc_noise_detect); // RULE13

		state_next.aux_out = amr_line_route(state_reg.regs.auxiliary_output_routing, 1'b0); // RULE14
		state_next.spk_out = amr_line_route(state_reg.regs.speaker_output_routing, 1'b0); // RULE15

		// headphone: in mono mode both mixer channels reach both sides
		state_next.hp_left_out = '0;
		state_next.hp_left_out.add_sidetone = hp[`AMR_BIT_OUT_SEL0]; // RULE16
		state_next.hp_left_out.add_phone_in = hp[`AMR_BIT_OUT_SEL1]; // RULE16
		state_next.hp_left_out.add_right = hp[`AMR_BIT_OUT_SEL2] & ~stereo_flag; // RULE17
		state_next.hp_left_out.add_left = hp[`AMR_BIT_OUT_SEL3]; // RULE18
		state_next.hp_left_out.silence = hp[`AMR_BIT_OUT_SILENCE4]; // RULE16
		state_next.hp_right_out = '0;
		state_next.hp_right_out.add_sidetone = hp[`AMR_BIT_OUT_SEL0]; // RULE16
		state_next.hp_right_out.add_phone_in = hp[`AMR_BIT_OUT_SEL1]; // RULE16
		state_next.hp_right_out.add_right = hp[`AMR_BIT_OUT_SEL2]; // RULE17
		state_next.hp_right_out.add_left = hp[`AMR_BIT_OUT_SEL3] & ~stereo_flag; // RULE18
		state_next.hp_right_out.silence = hp[`AMR_BIT_OUT_SILENCE4]; // RULE16

		// mono summing needs 6 dB more headroom
		state_next.hp_mix_gain = stereo_flag ? `AMR_HP_GAIN_STEREO_HDB : `AMR_HP_GAIN_MONO_HDB; // RULE19
		state_next.hp_voice_gain = `AMR_HP_GAIN_VOICE_HDB; // RULE19

		state_next.ear_out = '0;
		state_next.ear_out.add_sidetone = ep[`AMR_BIT_OUT_SEL0]; // RULE20
		state_next.ear_out.add_phone_in = ep[`AMR_BIT_OUT_SEL1]; // RULE20
		state_next.ear_out.add_right = ep[`AMR_BIT_OUT_SEL2]; // RULE20
		state_next.ear_out.add_left = ep[`AMR_BIT_OUT_SEL3]; // RULE20
		state_next.ear_out.silence = ep[`AMR_BIT_OUT_SILENCE4]; // RULE20
	end

	// the derived outputs trail the registers by one edge, the converter silence by two; reset shows all-zero gains
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= '0; // RULE22
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign reg_rsp = state_reg.rsp;
	assign phone_src = state_reg.phone_src;
	assign aux_left_src = state_reg.aux_left_src;
	assign aux_right_src = state_reg.aux_right_src;
	assign conv_left_src = state_reg.conv_left_src;
	assign conv_right_src = state_reg.conv_right_src;
	assign phone_output = state_reg.phone_out;
	assign aux_output = state_reg.aux_out;
	assign speaker_output = state_reg.spk_out;
	assign headphone_left_output = state_reg.hp_left_out;
	assign headphone_right_output = state_reg.hp_right_out;
	assign earpiece_output = state_reg.ear_out;
	assign headphone_mix_gain_hdb = state_reg.hp_mix_gain;
	assign headphone_voice_gain_hdb = state_reg.hp_voice_gain;
endmodule

/* File: verification/amr_mixer_regs_props.sv */
// port assertions for the mixer routing register bank
`timescale 1ns/1ps
module amr_mixer_regs_props (
	// clock and reset
	input logic sys_clk,
	input logic resetn,
	// register port and device state
	input amr_pkg::amr_req_s reg_req,
	input amr_pkg::amr_rsp_s reg_rsp,
	input logic stereo_flag,
	input logic conv_zero_cross_left,
	// derived outputs
	input amr_pkg::amr_src_s phone_src,
	input amr_pkg::amr_src_s aux_left_src,
	input amr_pkg::amr_src_s conv_left_src,
	input amr_pkg::amr_route_s phone_output,
	input amr_pkg::amr_route_s aux_output,
	input amr_pkg::amr_route_s speaker_output,
	input amr_pkg::amr_route_s headphone_left_output,
	input amr_pkg::amr_route_s headphone_right_output,
	input amr_pkg::amr_route_s earpiece_output,
	input logic signed [7:0] headphone_mix_gain_hdb,
	input logic signed [7:0] headphone_voice_gain_hdb
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// outputs are only meaningful once one edge has passed after reset
	logic live_reg;
	logic [7:0] wd1_reg, wd2_reg;
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			live_reg <= 1'b0;
			wd1_reg <= 8'h00;
			wd2_reg <= 8'h00;
		end
		else
		begin
			live_reg <= 1'b1;
			wd1_reg <= reg_req.wdata;
			wd2_reg <= wd1_reg;
		end
	end
	a_read_answer: assert property (live_reg |-> reg_rsp.rvalid == $past(reg_req.rd))
		else $error("read answer out of step");
	a_phone_gain_code: assert property (reg_req.wr && reg_req.addr == 8'h0e |-> ##2
		$signed(phone_src.gain_hdb) == 3 * int'(wd2_reg[4:0]) - 69 && phone_src.silence == wd2_reg[5])
		else $error("phone input gain or mute wrong");
	a_aux_gain_code: assert property (reg_req.wr && reg_req.addr == 8'h0f |-> ##2
		$signed(aux_left_src.gain_hdb) == 3 * int'(wd2_reg[4:0]) - 93 + 24 * int'(wd2_reg[5]))
		else $error("left aux gain wrong");
	a_aux_flag_bits: assert property (reg_req.wr && reg_req.addr == 8'h0f |-> ##2
		aux_left_src.silence == wd2_reg[6] && aux_left_src.take_aux == wd2_reg[7])
		else $error("left aux mute or source wrong");
	a_phone_out_bits: assert property (reg_req.wr && reg_req.addr == 8'h12 |-> ##2
		phone_output.silence == wd2_reg[3] && phone_output[2:1] == wd2_reg[2:1] && phone_output[4:3] == 2'b00)
		else $error("phone output routing wrong");
	a_aux_out_bits: assert property (reg_req.wr && reg_req.addr == 8'h13 |-> ##2
		aux_output == {1'b0, wd2_reg[0], 1'b0, wd2_reg[2:1], wd2_reg[3]})
		else $error("aux output routing wrong");
	a_speaker_out_bits: assert property (reg_req.wr && reg_req.addr == 8'h14 |-> ##2
		speaker_output == {1'b0, wd2_reg[0], 1'b0, wd2_reg[2:1], wd2_reg[3]})
		else $error("speaker output routing wrong");
	a_earpiece_out_bits: assert property (reg_req.wr && reg_req.addr == 8'h16 |-> ##2
		earpiece_output == {1'b0, wd2_reg[1], wd2_reg[0], wd2_reg[3], wd2_reg[2], wd2_reg[4]})
		else $error("earpiece routing wrong");
	a_hp_amp_gains: assert property (live_reg |-> headphone_voice_gain_hdb == -12 &&
		headphone_mix_gain_hdb == ($past(stereo_flag) ? -12 : -24))
		else $error("headphone gain wrong");
	a_hp_stereo_split: assert property (live_reg && $past(stereo_flag) |->
		!headphone_left_output.add_right && !headphone_right_output.add_left)
		else $error("stereo headphone channel crossed");
	a_hp_mono_same: assert property (live_reg && !$past(stereo_flag) |->
		headphone_left_output == headphone_right_output)
		else $error("mono headphone sides differ");
	a_conv_mute_crossing: assert property (live_reg && $changed(conv_left_src.silence) |->
		$past(conv_zero_cross_left, 2))
		else $error("converter mute changed off a crossing");
endmodule
bind amr_mixer_regs amr_mixer_regs_props u_props (.sys_clk, .resetn, .reg_req, .reg_rsp, .stereo_flag,
	.conv_zero_cross_left, .phone_src, .aux_left_src, .conv_left_src, .phone_output, .aux_output,
	.speaker_output, .headphone_left_output, .headphone_right_output, .earpiece_output,
	.headphone_mix_gain_hdb, .headphone_voice_gain_hdb);

/* File: verification/amr_mixer_regs_tb.sv */
// self-checking bench for the mixer routing register bank
`timescale 1ns/1ps
module amr_mixer_regs_tb;
	logic sys_clk, resetn, stereo_flag, noise_gate_on, agc_noise_detect;
	logic conv_zero_cross_left, conv_zero_cross_right;
	amr_pkg::amr_req_s reg_req;
	amr_pkg::amr_rsp_s reg_rsp;
	amr_pkg::amr_src_s phone_src, aux_left_src, aux_right_src, conv_left_src, conv_right_src;
	amr_pkg::amr_route_s phone_output, aux_output, speaker_output, earpiece_output;
	amr_pkg::amr_route_s headphone_left_output, headphone_right_output;
	logic signed [7:0] headphone_mix_gain_hdb, headphone_voice_gain_hdb;
	int errors, compares, cycles;
	logic [7:0] m [9];
	logic csil [2];
	amr_mixer_regs dut (.sys_clk, .resetn, .reg_req, .reg_rsp, .stereo_flag, .noise_gate_on,
		.agc_noise_detect, .conv_zero_cross_left, .conv_zero_cross_right, .phone_src, .aux_left_src,
		.aux_right_src, .conv_left_src, .conv_right_src, .phone_output, .aux_output, .speaker_output,
		.headphone_left_output, .headphone_right_output, .earpiece_output, .headphone_mix_gain_hdb,
		.headphone_voice_gain_hdb);
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic print_verdict();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			errors++;
			print_verdict();
		end
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [7:0] gain(input logic [4:0] c, input logic b);
		return 8'(3 * int'(c) - 93 + (b ? 24 : 0));
	endfunction
	function automatic logic [7:0] msk(input int i);
		return i == 0 ? 8'h3f : i < 4 ? 8'hff : i == 5 || i == 6 ? 8'h0f : 8'h1f;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_req.addr <= a;
		reg_req.wdata <= d;
		reg_req.wr <= 1'b1;
		@(posedge sys_clk);
		reg_req.wr <= 1'b0;
		if (a >= 8'h0e && a <= 8'h16)
			m[a - 8'h0e] = d & msk(a - 8'h0e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_req.addr <= a;
		reg_req.rd <= 1'b1;
		@(posedge sys_clk);
		reg_req.rd <= 1'b0;
		#1;
		chk("rvalid", reg_rsp.rvalid, 8'h01);
		chk("rdata", reg_rsp.rdata, exp);
	endtask
	task automatic check_all();
		logic [4:0] c;
		logic [7:0] h;
		logic [7:0] p;
		logic s;
		amr_pkg::amr_src_s a [2];
		amr_pkg::amr_src_s v [2];
		a = '{aux_left_src, aux_right_src};
		v = '{conv_left_src, conv_right_src};
		h = m[7];
		p = m[4];
		s = stereo_flag;
		chk("phone gain", phone_src.gain_hdb, gain(m[0][4:0], 1'b1));
		chk("phone mute", {phone_src.take_aux, phone_src.silence}, {1'b0, m[0][5]});
		for (int i = 0; i < 2; i++)
		begin
			c = m[3][5] ? m[1 + i][4:0] : m[3][4:0];
			chk("aux gain", a[i].gain_hdb, gain(m[1 + i][4:0], m[1 + i][5]));
			chk("aux flags", {a[i].take_aux, a[i].silence}, m[1 + i][7:6]);
			chk("conv gain", v[i].gain_hdb, gain(c, m[3][6]));
			chk("conv mute", {v[i].take_aux, v[i].silence}, {1'b0, csil[i]});
		end
		chk("phone out", phone_output, {p[0] & !(p[4] & noise_gate_on & agc_noise_detect), 2'b00, p[2:1], p[3]});
		chk("aux out", aux_output, {1'b0, m[5][0], 1'b0, m[5][2:1], m[5][3]});
		chk("speaker out", speaker_output, {1'b0, m[6][0], 1'b0, m[6][2:1], m[6][3]});
		chk("hp left", headphone_left_output, {1'b0, h[1:0], h[3], h[2] & !s, h[4]});
		chk("hp right", headphone_right_output, {1'b0, h[1:0], h[3] & !s, h[2], h[4]});
		chk("earpiece", earpiece_output, {1'b0, m[8][1:0], m[8][3], m[8][2], m[8][4]});
		chk("hp mix gain", headphone_mix_gain_hdb, s ? 8'hf4 : 8'he8);
		chk("hp voice gain", headphone_voice_gain_hdb, 8'hf4);
	endtask
	initial
	begin
		int i;
		logic [7:0] d;
		logic [1:0] z;
		logic [7:0] corner [4];
		corner = '{8'h00, 8'hff, 8'h1f, 8'he0};
		void'($urandom(40339));
		resetn = 1'b0;
		reg_req = '0;
		{stereo_flag, noise_gate_on, agc_noise_detect} = 3'b000;
		{conv_zero_cross_left, conv_zero_cross_right} = 2'b00;
		m = '{default: 8'h00};
		csil = '{default: 1'b0};
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		#1;
		check_all();
		for (int j = 0; j < 9; j++)
			rd(8'(14 + j), 8'h00);
		for (int k = 0; k < 200; k++)
		begin
			i = k < 36 ? k % 9 : $urandom % 9;
			d = k < 36 ? corner[k / 9] : 8'($urandom);
			@(posedge sys_clk);
			{stereo_flag, noise_gate_on, agc_noise_detect} <= 3'($urandom);
			// an occasional write to an unmapped place must change nothing
			wr(k % 50 == 7 ? 8'h17 : 8'(14 + i), d);
			@(posedge sys_clk);
			z = 2'($urandom);
			{conv_zero_cross_left, conv_zero_cross_right} <= z;
			@(posedge sys_clk);
			{conv_zero_cross_left, conv_zero_cross_right} <= 2'b00;
			if (z[1])
				csil[0] = m[3][7];
			if (z[0])
				csil[1] = m[3][7];
			@(posedge sys_clk);
			#1;
			check_all();
			i = $urandom % 9;
			rd(8'(14 + i), m[i]);
		end
		rd(8'h0d, 8'h00);
		rd(8'h17, 8'h00);
		rd(8'hff, 8'h00);
		print_verdict();
	end
endmodule
